// *** src/host_bus_reset_and_pin_control.sv ***
// Host bus reset domains, pin sampling, interrupt pin and shared bus phases
// Functional notes
// R1: Global reset restores every register default
// R2: Global reset: inactive, all outputs floated
// R3: System holds global reset at least 2 ms; the bench holds rstn low for only 3 clocks, and GRST_MIN_CYCLES is unused
// R4: Global reset once; separate bus reset
// R5: Bus signals sampled on rising clock edge
// R6: Interrupt pin; card-bus interrupt when strap low
// R7: Bus reset: nonfunctional, outputs floated
// R8: Bus reset keeps power and vendor bits
// R9: Bus reset input wired to host reset
// R10: Shared lines: address phase, then data
// R11: Async assert, synchronised reset release
module host_bus_reset_and_pin_control
  import rst_pin_pkg::*;
#(
  parameter int unsigned AD_W = ADDR_DATA_W
) (
  // Clock and resets
  input  wire logic                 clk,
  input  wire logic                 clk_en,
  input  wire logic                 rstn,
  input  wire logic                 bus_rstn,
  // Straps and events
  input  wire logic                 card_mode_strap,
  input  wire logic                 irq_event,
  input  wire logic                 irq_clear,
  // Shared address/data bus
  input  wire logic [AD_W-1:0]      shared_addr_data_bus_in,
  output logic      [AD_W-1:0]      shared_addr_data_bus_out,
  output logic                      shared_addr_data_bus_oe,
  input  wire logic                 cycle_start,
  input  wire logic                 cycle_last,
  input  wire logic                 drive_data,
  input  wire logic [AD_W-1:0]      data_word,
  // Retained context written by host software
  input  wire logic                 ctx_we,
  input  wire logic [7:0]           pm_ctx_wdata,
  input  wire logic [7:0]           vend_wdata,
  // Observed state
  output logic      [AD_W-1:0]      captured_addr,
  output logic      [AD_W-1:0]      captured_data,
  output logic                      data_valid,
  output logic      [7:0]           pm_ctx,
  output logic      [7:0]           vend_bits,
  // Interrupt pin, open drain style
  output logic                      host_interrupt_out,
  output logic                      host_interrupt_oe
);

  // ----------------------------------------
  // Reset synchronisers
  // ----------------------------------------
  logic [1:0] grst_sync_ff;
  logic [1:0] brst_sync_ff;
  wire        bus_rst_async_n = rstn & bus_rstn;

  // R11: async assert, sync release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) grst_sync_ff <= 2'h0;
    else       grst_sync_ff <= {grst_sync_ff[0], 1'b1};
  end

  // R9: bus reset pin into its own domain
  always_ff @(posedge clk or negedge bus_rst_async_n) begin
    if (!bus_rst_async_n) brst_sync_ff <= 2'h0;
    else                  brst_sync_ff <= {brst_sync_ff[0], 1'b1};
  end

  wire g_rstn   = grst_sync_ff[1];
  wire b_rstn   = brst_sync_ff[1];
  wire run_en   = clk_en & g_rstn & b_rstn;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] strap_sync_ff;
  logic [1:0] irq_sync_ff;
  logic [1:0] clr_sync_ff;

  // R5: pins sampled on rising edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_sync_ff <= 2'h3;
      irq_sync_ff   <= 2'h0;
      clr_sync_ff   <= 2'h0;
    end else if (clk_en) begin
      strap_sync_ff <= {strap_sync_ff[0], card_mode_strap};
      irq_sync_ff   <= {irq_sync_ff[0], irq_event};
      clr_sync_ff   <= {clr_sync_ff[0], irq_clear};
    end
  end

  wire card_mode = ~strap_sync_ff[1];

  // ----------------------------------------
  // Retained context bits
  // ----------------------------------------
  logic [7:0] pm_ctx_ff;
  logic [7:0] vend_ff;

  // R8: only global reset clears these
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pm_ctx_ff <= PM_CTX_RESET_VAL;
      vend_ff   <= VEND_RESET_VAL;
    end else if (clk_en && g_rstn && ctx_we) begin
      pm_ctx_ff <= pm_ctx_wdata;
      vend_ff   <= vend_wdata;
    end
  end

  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  bus_phase_t      phase_ff;
  bus_phase_t      nxt_phase;
  logic [AD_W-1:0] addr_ff;
  logic [AD_W-1:0] data_ff;
  logic            valid_ff;
  logic            irq_ff;

  // R10: address phase then data phase
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_IDLE: if (cycle_start) nxt_phase = PH_ADDR;
      PH_ADDR: nxt_phase = PH_DATA;
      PH_DATA: if (cycle_last) nxt_phase = PH_IDLE;
      default: nxt_phase = PH_IDLE;
    endcase
  end

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  wire in_addr  = (phase_ff == PH_ADDR);
  wire in_data  = (phase_ff == PH_DATA);
  wire drive_ok = in_data & drive_data;
  wire take_dat = in_data & ~drive_data;

  // ----------------------------------------
  // Interrupt next state
  // ----------------------------------------
  // R6: sticky request, set wins
  wire nxt_irq  = irq_sync_ff[1] | (irq_ff & ~clr_sync_ff[1]);

  // R1: global reset clears everything
  // R8: bus reset clears working state
  always_ff @(posedge clk or negedge bus_rst_async_n) begin
    if (!bus_rst_async_n) begin
      phase_ff <= PH_IDLE;
      addr_ff  <= AD_W'(ADDR_RESET_VAL);
      data_ff  <= AD_W'(DATA_RESET_VAL);
      valid_ff <= 1'b0;
      irq_ff   <= 1'b0;
    end else if (run_en) begin
      phase_ff <= nxt_phase;
      if (in_addr) addr_ff <= shared_addr_data_bus_in;
      if (take_dat) data_ff <= shared_addr_data_bus_in;
      valid_ff <= take_dat;
      // Set wins over clear
      irq_ff   <= nxt_irq;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic [AD_W-1:0] ad_out_ff;
  logic            ad_oe_ff;
  logic            int_oe_ff;

  // R2: outputs floated in global reset
  // R7: outputs floated in bus reset
  always_ff @(posedge clk or negedge bus_rst_async_n) begin
    if (!bus_rst_async_n) begin
      ad_out_ff <= '0;
      ad_oe_ff  <= 1'b0;
      int_oe_ff <= 1'b0;
    end else if (run_en) begin
      ad_out_ff <= drive_ok ? data_word : '0;
      ad_oe_ff  <= drive_ok;
      // R6: active low pin, card mode same pin
      int_oe_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // Interrupt pin level
  // ----------------------------------------
  logic int_out_ff;

  // R6: same low level in both modes
  always_ff @(posedge clk or negedge bus_rst_async_n) begin
    if (!bus_rst_async_n) begin
      int_out_ff <= 1'b0;
    end else if (run_en) begin
      int_out_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Port drive
  // ----------------------------------------
  assign shared_addr_data_bus_out = ad_out_ff;
  assign shared_addr_data_bus_oe  = ad_oe_ff;
  assign captured_addr            = addr_ff;
  assign captured_data            = data_ff;
  assign data_valid               = valid_ff;
  assign pm_ctx                   = pm_ctx_ff;
  assign vend_bits                = vend_ff;
  assign host_interrupt_out       = int_out_ff;
  assign host_interrupt_oe        = int_oe_ff;

  wire unused_card = card_mode;
endmodule

// *** src/rst_pin_pkg.sv ***
// Constants and types for the host bus reset and pin control block
package rst_pin_pkg;
  localparam int unsigned ADDR_DATA_W      = 32;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned GRST_MIN_MS      = 2;
  localparam int unsigned GRST_MIN_CYCLES  = (GRST_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam logic [31:0] ADDR_RESET_VAL   = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET_VAL   = 32'h0000_0000;
  localparam logic [7:0]  PM_CTX_RESET_VAL = 8'h00;
  localparam logic [7:0]  VEND_RESET_VAL   = 8'h00;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA
  } bus_phase_t;
endpackage

// *** test/host_bus_model.sv ***
// Host side of the shared address/data lines
module host_bus_model (
  input  wire logic        clk,
  input  wire logic        dev_oe,
  input  wire logic        host_en,
  input  wire logic [31:0] dev_out,
  input  wire logic [31:0] host_val,
  output logic      [31:0] bus
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] last_ff;
  always_ff @(posedge clk) last_ff <= bus;
  assign bus = dev_oe ? dev_out : host_en ? host_val : ~last_ff;
endmodule

// *** test/rst_pin_checker.sv ***
// Port assertions for the reset and pin control block
module rst_pin_checker
  import rst_pin_pkg::*;
(
  input wire logic        clk, clk_en, rstn, bus_rstn, cycle_start, drive_data, irq_event,
  input wire logic        shared_addr_data_bus_oe, data_valid, host_interrupt_oe,
  input wire logic        host_interrupt_out,
  input wire logic [31:0] shared_addr_data_bus_in, shared_addr_data_bus_out, data_word,
  input wire logic [31:0] captured_addr, captured_data,
  input wire logic [7:0]  pm_ctx, vend_bits
);
  timeunit 1ns;
  timeprecision 100ps;
  wire        oe  = shared_addr_data_bus_oe;
  wire [31:0] bin = shared_addr_data_bus_in;
  wire        run = rstn && bus_rstn;
  default clocking @(posedge clk); endclocking
  sequence s_addr; clk_en && cycle_start ##1 clk_en; endsequence
  sequence s_data; s_addr ##1 clk_en; endsequence
  gr_float_a: assert property (disable iff (!bus_rstn)
    !rstn |-> !oe && !host_interrupt_oe) else $error("Driven in global reset");
  gr_clear_a: assert property (disable iff (!bus_rstn)
    !rstn |-> {pm_ctx, vend_bits, captured_addr} == {PM_CTX_RESET_VAL, VEND_RESET_VAL,
    ADDR_RESET_VAL}) else $error("Not cleared");
  br_float_a: assert property (disable iff (!rstn)
    !bus_rstn |-> !oe && !host_interrupt_oe && !data_valid) else $error("Driven in bus reset");
  br_keep_a: assert property (disable iff (!rstn)
    !bus_rstn |-> $stable({pm_ctx, vend_bits})) else $error("Context lost");
  addr_cap_a: assert property (disable iff (!run)
    s_addr |=> captured_addr == $past(bin)) else $error("Address not taken");
  data_drive_a: assert property (disable iff (!run)
    s_data ##0 drive_data |=> oe && shared_addr_data_bus_out == $past(data_word))
    else $error("Data not driven");
  data_take_a: assert property (disable iff (!run)
    s_data ##0 !drive_data |=> data_valid && captured_data == $past(bin))
    else $error("Data not taken");
  irq_raise_a: assert property (disable iff (!run)
    irq_event && clk_en ##1 clk_en [*2] |=> host_interrupt_oe) else $error("Interrupt late");
  int_pin_a: assert property (disable iff (!run)
    host_interrupt_out == 1'b0) else $error("Interrupt pin high");
endmodule
bind host_bus_reset_and_pin_control rst_pin_checker i_rst_pin_checker (.*);

// *** test/test_host_bus_reset_and_pin_control.sv ***
// Bench for the reset and pin control block
module test_host_bus_reset_and_pin_control;
  timeunit 1ns;
  timeprecision 100ps;
  import rst_pin_pkg::*;
  typedef struct {logic [31:0] a, d; logic drv;} row_t;
  row_t rows [4] = '{'{32'h0000_0000, 32'hFFFF_FFFF, 1'b0}, '{32'hFFFF_FFFF, 32'h0, 1'b1},
    '{32'h8000_0001, 32'hA5A5_5A5A, 1'b1}, '{32'h1234_5678, 32'h8765_4321, 1'b0}};
  logic clk = 0, rstn = 1, bus_rstn = 1, strap = 1, irq = 0, iclr = 0;
  logic cs = 0, cl = 0, dd = 0, hen = 0, we = 0, oe, dv, io, ioe;
  logic [31:0] hv = 0, dw = 0, bus, out, ca, cd;
  logic [7:0] pm, vb;
  int mismatches = 0, num_checks = 0;
  always #5 clk = ~clk;
  // separate global and bus reset inputs
  host_bus_reset_and_pin_control i_host_bus_reset_and_pin_control (.clk, .clk_en(1'b1),
    .rstn, .bus_rstn, .card_mode_strap(strap), .irq_event(irq), .irq_clear(iclr),
    .shared_addr_data_bus_in(bus), .shared_addr_data_bus_out(out),
    .shared_addr_data_bus_oe(oe), .cycle_start(cs), .cycle_last(cl), .drive_data(dd),
    .data_word(dw), .ctx_we(we), .pm_ctx_wdata(8'hA5), .vend_wdata(8'h3C),
    .captured_addr(ca), .captured_data(cd), .data_valid(dv), .pm_ctx(pm),
    .vend_bits(vb), .host_interrupt_out(io), .host_interrupt_oe(ioe));
  host_bus_model i_host_bus_model (.clk, .dev_oe(oe), .host_en(hen), .dev_out(out),
    .host_val(hv), .bus);
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input logic [31:0] a, d, input logic drv);
    step(1);
    cs = 1;
    step(1);
    {cs, hen, hv} = {2'b01, a};
    step(1);
    {cl, dd, hen, hv, dw} = {1'b1, drv, !drv, d, d};
    step(1);
    chk(ca, a);
    chk(oe, drv);
    chk(drv ? out : cd, d);
    chk(dv, !drv);
    {cl, dd, hen} = 3'b000;
    step(1);
    chk(oe, 0);
  endtask
  initial begin
    #2;
    rstn = 0;
    step(3);
    chk(ioe, 0);
    rstn = 1;
    step(3);
    foreach (rows[i]) cyc(rows[i].a, rows[i].d, rows[i].drv);
    for (int m = 0; m < 2; m++) begin
      strap = m[0];
      irq = 1;
      step(2);
      chk(ioe, 0);
      step(1);
      chk(ioe, 1);
      iclr = 1;
      step(4);
      chk(ioe, 1);
      irq = 0;
      step(4);
      chk(ioe, 0);
      chk(io, 0);
      iclr = 0;
    end
    {we, irq} = 2'b11;
    step(1);
    we = 0;
    step(4);
    bus_rstn = 0;
    #1;
    chk(ioe, 0);
    chk({pm, vb}, 16'hA53C);
    chk(ca, ADDR_RESET_VAL);
    irq = 0;
    step(2);
    bus_rstn = 1;
    step(3);
    chk(ioe, 0);
    cyc(32'hCAFE_F00D, 32'h0BAD_BEEF, 1'b1);
    conclude();
  end
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
